// File: bench/core_model.sv
`timescale 1ns/100ps
`default_nettype none
module core_model #(
  parameter logic [14:0] NOCONC_START = 15'h3800 // first no-concurrent word
) (
  input wire logic sys_clk,          // core clock
  input wire logic [14:0] want_pc,   // address the bench wants to run
  input wire logic want_lpm,         // bench asks for a load
  input wire logic [14:0] want_addr, // wanted load address
  input wire logic halt,             // core held by programming
  input wire logic busy,             // concurrent section blocked
  output logic [14:0] pc,            // executing address
  output logic lpm_req,              // load request
  output logic [14:0] lpm_addr       // load address
);
  // defined levels before the first edge
  initial begin
    pc = 15'h0000;
    lpm_req = 1'b0;
    lpm_addr = 15'h0000;
  end
  // a held core freezes; blocked section is never fetched or loaded
  always @(posedge sys_clk) begin
    if (!halt && !(busy && want_pc < NOCONC_START)) begin
      pc <= want_pc;
    end
    if (!halt) begin
      lpm_addr <= want_addr;
      lpm_req <= want_lpm && !(busy && want_addr < NOCONC_START);
    end
  end
endmodule
`default_nettype wire

// File: bench/tb_boot_flash_rww_protection.sv
`timescale 1ns/100ps
`default_nettype none
`include "rww_prot_map.svh"
module tb_boot_flash_rww_protection
  import flash_prot_pkg::*;
;
  localparam int PC = 16; // short erase/write time
  logic sys_clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [14:0] want_pc = 15'h0, want_addr = 15'h0, pc, lpm_addr;
  logic want_lpm = 1'b0, vec_in_boot = 1'b0, chip_erase = 1'b0;
  logic lpm_req, lpm_allow, core_halt, irq_block, busy, hresp, hreadyout;
  logic [3:0] lk;
  logic [1:0] fz;
  int failures = 0, checked = 0, cyc = 0, n;
  integer seed = 32'h61f294c5;
  logic [14:0] cpc [7] = '{15'h0100, 15'h3f10, 15'h3f10, 15'h3f10,
    15'h3f10, 15'h3f10, 15'h3f10};
  logic [14:0] ctg [7] = '{15'h0200, 15'h3f20, 15'h0200, 15'h0200,
    15'h3f80, 15'h3900, 15'h0300};
  logic [3:0] cl [7] = '{4'hf, 4'hf, 4'hf, 4'he, 4'hb, 4'hf, 4'h5};
  int cex [7] = '{0, 2, 1, 0, 0, 2, 1}; // 0 refused, 1 busy, 2 halt

  boot_flash_rww_protection #(.PROG_CYC(PC)) uut (.sys_clk(sys_clk),
    .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pc(pc),
    .lpm_req(lpm_req), .lpm_addr(lpm_addr), .vec_in_boot(vec_in_boot),
    .chip_erase(chip_erase), .lpm_allow(lpm_allow), .core_halt(core_halt),
    .irq_block(irq_block), .concurrent_section_busy_flag(busy));
  core_model cm (.sys_clk(sys_clk), .want_pc(want_pc), .want_lpm(want_lpm),
    .want_addr(want_addr), .halt(core_halt), .busy(busy), .pc(pc),
    .lpm_req(lpm_req), .lpm_addr(lpm_addr));

  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;
  // hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      failures++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one single-word transfer; read data lands in rd
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic erase_locks();
    @(posedge sys_clk);
    chip_erase <= 1'b1;
    @(posedge sys_clk);
    chip_erase <= 1'b0;
  endtask
  // reference model of the sections and lock bits
  function automatic logic inb(input logic [14:0] a);
    return a >= 15'h3f00 - {5'h0, fz, 8'h00};
  endfunction
  function automatic logic exp_lpm(input logic [14:0] p, input logic [14:0] a);
    if (!inb(p) && inb(a))
      return lk[3];
    if (inb(p) && !inb(a))
      return lk[1];
    return 1'b1;
  endfunction

  // main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    xfer(0, `LOCK_OFS, 0);
    chk(rd, 32'hf);
    xfer(0, 8'h1c, 0);
    chk(rd, 32'h0);
    want_lpm <= 1'b1;
    for (int i = 0; i < 24; i++) begin
      erase_locks();
      lk = 4'($random(seed));
      fz = 2'($random(seed));
      xfer(1, `LOCK_OFS, {28'h0, lk});
      xfer(1, `FUSE_OFS, {30'h0, fz});
      xfer(1, `LOCK_OFS, 32'hf);
      xfer(0, `LOCK_OFS, 0);
      chk(rd, {28'h0, lk});
      want_pc <= 15'h1c00 | 15'($random(seed) & 32'h23ff);
      want_addr <= 15'h1c00 | 15'($random(seed) & 32'h23ff);
      vec_in_boot <= 1'($random(seed));
      repeat (3) @(posedge sys_clk);
      #1;
      chk(lpm_allow, exp_lpm(want_pc, want_addr));
      chk(irq_block, (!inb(want_pc) && vec_in_boot && !lk[1]) ||
        (inb(want_pc) && !vec_in_boot && !lk[3]));
    end
    fz = 2'h0;
    want_lpm <= 1'b0;
    xfer(1, `FUSE_OFS, 0);
    for (int i = 0; i < 7; i++) begin
      erase_locks();
      xfer(1, `LOCK_OFS, {28'h0, cl[i]});
      want_pc <= cpc[i];
      repeat (2) @(posedge sys_clk);
      xfer(1, `PROG_OFS, {17'h0, ctg[i]});
      #1;
      chk(core_halt, cex[i] == 2);
      chk(busy, cex[i] == 1);
      n = 0;
      while (core_halt === 1'b1 && n < 100) begin
        @(posedge sys_clk);
        #1;
        n++;
      end
      if (cex[i] == 2)
        chk(n, PC);
      xfer(0, `STAT_OFS, 0);
      chk(rd[2], cex[i] == 0);
      if (cex[i] == 1) begin
        xfer(1, `CTRL_OFS, 32'h4);
        @(posedge sys_clk);
        #1;
        chk(busy, 1'b1);
        repeat (PC) @(posedge sys_clk);
        xfer(0, `STAT_OFS, 0);
        chk(rd[3:0], 4'h1);
        xfer(1, `CTRL_OFS, (i == 2) ? 32'h4 : 32'h8);
        @(posedge sys_clk);
        #1;
        chk(busy, 1'b0);
      end
    end
    wrap_up();
  end
endmodule
`default_nettype wire

// File: core/boot_flash_rww_protection.sv
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "rww_prot_map.svh"

// program flash guard: decides whether self-programming may start, whether
// the core is held while a page is erased or written, and whether a
// load-program access may see the other section
// register bus: ahb-lite, zero wait states, one aligned word per register
// ctrl: bit2 re-enable after completion, bit3 page-buffer load, both clear busy
// stat: bit0 busy, bit1 halt, bit2 refused, bit3 programming
// lock: bits only fall through the bus; a write ands into the stored value
// fuse: two boot-size bits; each step moves the boundary down one block
// prog: writing a target word address starts an erase/write cycle
// hazard: the target comes from the data phase, so the halt decision uses
// the page address rather than where the core happens to execute
// limitation: erase and write share one duration; the sequencer does not
// tell them apart, real flash timing lives elsewhere
// trade-off: lpm_allow and irq_block are registered, so they lag the core
// by one cycle; a caller waits one cycle for the answer

// Contract
// - store-program from application section never starts programming.
// - store-program from boot loader may target any flash address.
// - boot-size fuses set the application/boot loader boundary.
// - fixed concurrent and no-concurrent sections; boot loader lies in latter.
// - concurrent-section programming keeps core running.
// - no-concurrent-section programming halts core for whole operation.
// - halt decision comes from target page address only.
// - busy flag reads one while concurrent section is blocked.
// - lock bits only programmed by software; cleared by chip erase only; srst here also restores them.
// - general write lock does not affect store-program.
// - general read/write lock does not affect load or store program.
// - application mode 1 places no restriction on application access.
// - application write-protect bit zero blocks writes to application.
// - application read-protect zero blocks boot loader reads of application.
// - app modes 3/4, vectors in boot: interrupts off in application.
// - boot mode 1 places no restriction on boot loader access.
// - boot write-protect bit zero blocks writes to boot loader.
// - boot read-protect zero blocks application reads of boot loader.
// - boot modes 3/4, vectors in app: interrupts off in boot loader.
// - busy flag clears on re-enable after completion or page-buffer load.
module boot_flash_rww_protection
  import flash_prot_pkg::*;
#(
  parameter int ADDR_W = 15,            // word address width
  parameter logic [14:0] NOCONC_START = 15'h3800, // first no-concurrent word
  parameter logic [14:0] BOOT_BASE = 15'h3f00,  // smallest boot section
  parameter logic [14:0] BOOT_STEP = 15'h0100,  // boot size step
  parameter int PROG_CYC = `PROG_CYCLES // erase/write duration in cycles
) (
  input wire logic sys_clk,             // core clock
  input wire logic srst,                // synchronous reset, active high
  input wire logic hsel,                // ahb-lite select
  input wire logic [31:0] haddr,        // ahb-lite address
  input wire logic [1:0] htrans,        // ahb-lite transfer type
  input wire logic hwrite,              // ahb-lite write
  input wire logic [2:0] hsize,         // ahb-lite size
  input wire logic [31:0] hwdata,       // ahb-lite write data
  input wire logic hready,              // ahb-lite bus ready
  output logic [31:0] hrdata,           // ahb-lite read data
  output logic hreadyout,               // ahb-lite slave ready
  output logic hresp,                   // ahb-lite response, always okay
  input wire logic [ADDR_W-1:0] pc,     // executing word address
  input wire logic lpm_req,             // load-program request
  input wire logic [ADDR_W-1:0] lpm_addr, // load-program word address
  input wire logic vec_in_boot,         // interrupt vectors in boot section
  input wire logic chip_erase,          // chip erase pulse from programmer
  output logic lpm_allow,               // load-program allowed
  output logic core_halt,               // core held during programming
  output logic irq_block,               // interrupts disabled
  output logic concurrent_section_busy_flag // concurrent section blocked
);

  typedef struct packed {
    prog_state_t st;
    logic [15:0] cnt;
    logic [ADDR_W-1:0] target;
    logic [3:0] locks;
    logic [1:0] boot_size_fuses;
    logic busy;
    logic refused;
    logic lpm_allow;
    logic irq_block;
    logic halt;
    logic ph_wr;
    logic ph_rd;
    logic [7:0] ph_addr;
    logic [31:0] rdata;
    logic bus_ready;
    logic bus_err;
    logic [15:0] halt_run;
  } state_t;

  state_t s_reg, s_next;
  logic [ADDR_W-1:0] boot_start;
  logic pc_in_boot, tgt_in_boot, tgt_in_noconc, lpm_in_boot;
  logic app_mode34, boot_mode34, wr_ok, start_cmd, addr_ok;

  // section boundaries from the fuses
  always_comb begin
    boot_start = BOOT_BASE - ADDR_W'(s_reg.boot_size_fuses) * BOOT_STEP;
    pc_in_boot = (pc >= boot_start);
    tgt_in_boot = (hwdata[ADDR_W-1:0] >= boot_start);
    tgt_in_noconc = (hwdata[ADDR_W-1:0] >= NOCONC_START);
    lpm_in_boot = (lpm_addr >= boot_start);
    app_mode34 = !s_reg.locks[`LOCK_APP_RP_BIT];
    boot_mode34 = !s_reg.locks[`LOCK_BOOT_RP_BIT];
  end

  // write permission: only the write-protect bit of the target's section matters, general locks unused
  always_comb begin
    if (tgt_in_boot) begin
      wr_ok = s_reg.locks[`LOCK_BOOT_WP_BIT];
    end else begin
      wr_ok = s_reg.locks[`LOCK_APP_WP_BIT];
    end
  end

  assign addr_ok = (s_reg.ph_addr[1:0] == 2'h0);
  assign start_cmd = s_reg.ph_wr && addr_ok && s_reg.ph_addr == `PROG_OFS;

  // next state: bus, programming sequencer, access checks
  always_comb begin
    s_next = s_reg;
    s_next.ph_wr = hsel && hready && htrans[1] && hwrite;
    s_next.ph_rd = hsel && hready && htrans[1] && !hwrite;
    if (hsel && hready && htrans[1]) begin
      s_next.ph_addr = haddr[7:0];
    end
    // control writes
    if (s_reg.ph_wr && s_reg.ph_addr == `CTRL_OFS) begin
      if (hwdata[`CTRL_REEN_BIT] && s_reg.st == ST_IDLE) begin
        s_next.busy = 1'b0;
      end
      if (hwdata[`CTRL_LOAD_BIT]) begin
        s_next.busy = 1'b0;
      end
    end
    // locks only drop to zero by software; only chip erase or srst restores ones
    if (s_reg.ph_wr && s_reg.ph_addr == `LOCK_OFS) begin
      s_next.locks = s_reg.locks & hwdata[3:0];
    end
    if (s_reg.ph_wr && s_reg.ph_addr == `FUSE_OFS) begin
      s_next.boot_size_fuses = hwdata[1:0];
    end
    case (s_reg.st)
      ST_IDLE: begin
        if (start_cmd) begin
          if (pc_in_boot && wr_ok) begin
            s_next.refused = 1'b0;
            s_next.target = hwdata[ADDR_W-1:0];
            s_next.cnt = 16'(PROG_CYC);
            if (tgt_in_noconc) begin
              s_next.st = ST_PROG_HALT;
              s_next.halt = 1'b1;
            end else begin
              s_next.st = ST_PROG_CONC;
              s_next.busy = 1'b1;
            end
          end else begin
            s_next.refused = 1'b1;
          end
        end
      end
      ST_PROG_CONC, ST_PROG_HALT: begin
        s_next.cnt = s_reg.cnt - 16'h0001;
        if (s_reg.cnt == 16'h0001) begin
          s_next.st = ST_IDLE;
          s_next.halt = 1'b0;
        end
      end
      default: s_next.st = ST_IDLE;
    endcase
    if (chip_erase) begin
      s_next.locks = `LOCK_RESET;
    end
    // load-program permission, checked against lock modes
    s_next.lpm_allow = 1'b1;
    if (lpm_req) begin
      if (pc_in_boot && !lpm_in_boot && app_mode34) begin
        s_next.lpm_allow = 1'b0;
      end
      if (!pc_in_boot && lpm_in_boot && boot_mode34) begin
        s_next.lpm_allow = 1'b0;
      end
    end
    // interrupt blocking when the executing section is read-protected and the vectors sit in the other section
    s_next.irq_block = (app_mode34 && vec_in_boot && !pc_in_boot)
      || (boot_mode34 && !vec_in_boot && pc_in_boot);
    // read data for the next data phase
    s_next.rdata = 32'h0;
    case (haddr[7:0])
      `CTRL_OFS: s_next.rdata = 32'h0;
      `STAT_OFS: s_next.rdata = {28'h0, s_reg.st != ST_IDLE, s_reg.refused,
        s_reg.halt, s_reg.busy};
      `LOCK_OFS: s_next.rdata = {28'h0, s_reg.locks};
      `FUSE_OFS: s_next.rdata = {30'h0, s_reg.boot_size_fuses};
      `PROG_OFS: s_next.rdata = 32'(s_reg.target);
      default: s_next.rdata = 32'h0;
    endcase
    // bus handshake outputs kept in flops so every output is registered
    s_next.bus_ready = 1'b1;
    s_next.bus_err = 1'b0;
    // length of the current halt, only read by the duration check
    s_next.halt_run = s_reg.halt ? s_reg.halt_run + 16'h0001 : 16'h0000;
    if (srst) begin
      s_next = '0;
      s_next.st = ST_IDLE;
      s_next.locks = `LOCK_RESET;
      s_next.boot_size_fuses = `FUSE_RESET;
      s_next.lpm_allow = 1'b1;
      s_next.bus_ready = 1'b1;
    end
  end

  // single state register
  always_ff @(posedge sys_clk) begin
    s_next_q: s_reg <= s_next;
  end

  assign hrdata = s_reg.rdata;
  assign hreadyout = s_reg.bus_ready; // zero wait states keep the bus simple
  assign hresp = s_reg.bus_err;
  assign lpm_allow = s_reg.lpm_allow;
  assign core_halt = s_reg.halt;
  assign irq_block = s_reg.irq_block;
  assign concurrent_section_busy_flag = s_reg.busy;

  // checks on the programming sequencer
  halt_on_noconc_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    (s_reg.st == ST_PROG_HALT) |->
    s_reg.halt)
    else $error("core not halted during no-concurrent programming");
  no_halt_conc_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    (s_reg.st == ST_PROG_CONC) |->
    !s_reg.halt)
    else $error("core halted during concurrent programming");
  busy_conc_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    (s_reg.st == ST_PROG_CONC) |->
    s_reg.busy)
    else $error("busy flag low while concurrent section programmed");
  idle_no_halt_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    (s_reg.st == ST_IDLE) |->
    !s_reg.halt)
    else $error("core held with no programming running");
  halt_len_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    $fell(s_reg.halt) |->
    (s_reg.halt_run == 16'(PROG_CYC)))
    else $error("halt did not cover the whole operation");
  prog_len_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    ($rose(s_reg.halt)) |->
    s_reg.halt [*8])
    else $error("halt ended early");

  // start decisions: executing section, lock bits, target section
  app_refuse_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    (start_cmd && s_reg.st == ST_IDLE && !pc_in_boot) |=>
    (s_reg.st == ST_IDLE && s_reg.refused))
    else $error("programming started from application section");
  boot_start_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    (start_cmd && s_reg.st == ST_IDLE && pc_in_boot && wr_ok) |=>
    (s_reg.st != ST_IDLE))
    else $error("allowed programming from boot loader not started");
  halt_start_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    (start_cmd && s_reg.st == ST_IDLE && pc_in_boot && wr_ok &&
    tgt_in_noconc) |=> (s_reg.halt && s_reg.st == ST_PROG_HALT))
    else $error("no-concurrent target did not halt the core");
  conc_start_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    (start_cmd && s_reg.st == ST_IDLE && pc_in_boot && wr_ok &&
    !tgt_in_noconc) |=> (s_reg.busy && !s_reg.halt))
    else $error("concurrent target did not run concurrently");
  halt_target_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    (s_reg.st == ST_PROG_HALT) |->
    (s_reg.target >= NOCONC_START))
    else $error("halt chosen for a concurrent-section page");
  conc_target_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    (s_reg.st == ST_PROG_CONC) |->
    (s_reg.target < NOCONC_START))
    else $error("concurrent run chosen for a no-concurrent page");
  app_wp_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    (start_cmd && s_reg.st == ST_IDLE && !tgt_in_boot &&
    !s_reg.locks[`LOCK_APP_WP_BIT]) |=> s_reg.st == ST_IDLE)
    else $error("write to protected application section started");
  boot_wp_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    (start_cmd && s_reg.st == ST_IDLE && tgt_in_boot &&
    !s_reg.locks[`LOCK_BOOT_WP_BIT]) |=> s_reg.st == ST_IDLE)
    else $error("write to protected boot section started");

  // section layout
  boot_in_noconc_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    1'b1 |->
    (boot_start >= NOCONC_START))
    else $error("boot loader reaches into the concurrent section");
  fuse_load_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    (s_reg.ph_wr && s_reg.ph_addr == `FUSE_OFS) |=>
    (s_reg.boot_size_fuses == $past(hwdata[1:0])))
    else $error("boot size setting not taken");

  // load-program and interrupt gating
  app_rp_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    (lpm_req && pc_in_boot && !lpm_in_boot && app_mode34) |=>
    !lpm_allow)
    else $error("boot read of protected application allowed");
  boot_rp_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    (lpm_req && !pc_in_boot && lpm_in_boot && boot_mode34) |=>
    !lpm_allow)
    else $error("application read of protected boot allowed");
  lpm_free_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    (lpm_req && !app_mode34 && !boot_mode34) |=>
    lpm_allow)
    else $error("load refused with no read protection");
  irq_app_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    (app_mode34 && vec_in_boot && !pc_in_boot) |=>
    irq_block)
    else $error("interrupts left on in application section");
  irq_boot_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    (boot_mode34 && !vec_in_boot && pc_in_boot) |=>
    irq_block)
    else $error("interrupts left on in boot loader section");
  irq_free_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    (!app_mode34 && !boot_mode34) |=>
    !irq_block)
    else $error("interrupts blocked with no read protection");

  // busy flag release and lock bits
  reen_clear_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    (s_reg.ph_wr && s_reg.ph_addr == `CTRL_OFS &&
    hwdata[`CTRL_REEN_BIT] && s_reg.st == ST_IDLE) |=> !s_reg.busy)
    else $error("re-enable after completion left busy set");
  load_clear_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    (s_reg.ph_wr && s_reg.ph_addr == `CTRL_OFS &&
    hwdata[`CTRL_LOAD_BIT]) |=> !s_reg.busy)
    else $error("page-buffer load left busy set");
  reen_early_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    (s_reg.ph_wr && s_reg.ph_addr == `CTRL_OFS && s_reg.busy &&
    !hwdata[`CTRL_LOAD_BIT] && s_reg.st != ST_IDLE) |=> s_reg.busy)
    else $error("busy cleared while programming still running");
  lock_sticky_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    (!chip_erase) |=>
    ((s_reg.locks & ~$past(s_reg.locks)) == 4'h0))
    else $error("lock bit returned to one without chip erase");
  erase_restore_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    chip_erase |=>
    (s_reg.locks == `LOCK_RESET))
    else $error("chip erase did not restore lock bits");

endmodule
`default_nettype wire

// File: shared/rww_prot_map.svh
`ifndef FLASH_PROT_MAP_SVH
`define FLASH_PROT_MAP_SVH
// register byte addresses on the ahb-lite slave
`define CTRL_OFS 8'h00
`define STAT_OFS 8'h04
`define LOCK_OFS 8'h08
`define FUSE_OFS 8'h0c
`define PROG_OFS 8'h10
// control register fields
`define CTRL_START_BIT 0
`define CTRL_ERASE_BIT 1
`define CTRL_REEN_BIT 2
`define CTRL_LOAD_BIT 3
// lock register fields (1 = unprogrammed)
`define LOCK_APP_WP_BIT 0
`define LOCK_APP_RP_BIT 1
`define LOCK_BOOT_WP_BIT 2
`define LOCK_BOOT_RP_BIT 3
`define LOCK_RESET 4'hf
// status register fields
`define STAT_BUSY_BIT 0
`define STAT_HALT_BIT 1
`define STAT_REFUSED_BIT 2
`define STAT_PROG_BIT 3
// fuse reset value and programming time
`define FUSE_RESET 2'h0
`define PROG_TIME_NS 1000
`define CLK_PERIOD_NS 20
`define PROG_CYCLES (`PROG_TIME_NS / `CLK_PERIOD_NS)
`endif

// File: shared/rww_prot_pkg.sv
package flash_prot_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PROG_CONC = 3'b010,
    ST_PROG_HALT = 3'b100
  } prog_state_t;
endpackage
